/* rtl/pgp_port_g.sv */
// Notes on behaviour
// - seven two-way pins 0..6, general-purpose I/O unless claimed
// - each direction bit sets its pin: 1 output, 0 input
// - direction register is write-only; reads return undefined (zero here)
// - direction resets 0, bit 0 resets 1 in modes 1 and 2
// - output data bit 7 reads 0, writes ignored
// - output data bits 6..0 read/write, reset 0, drive GPIO outputs
// - pin-state read returns output data where direction is 1
// - pin-state read returns pin level where direction is 0
// - pin-state register read-only, bit 7 undefined
// - pins 6,5 carry bus request/acknowledge when bus controller enables
// - pin 4 bus request output has top priority
// - chip select 7 enable: pin 4 drives select if direction 1
// - without chip select 7 enable or bus request output pin 4 is plain GPIO
// - pins 3..0 drive chip selects when enabled and direction 1
// - mode 7 without expansion: all pins plain GPIO
`include "pgp_map.svh"
`timescale 1ns/100ps
`default_nettype none
module pgp_port_g
#(
    parameter int PINS = 7
)
(
    // clock and reset
    input wire logic clk,
    input wire logic rstn,
    // operating mode strap
    input wire pgp_pkg::pgp_mode_t opMode,
    // register port
    input wire logic [3:0] regAddr,
    input wire logic [7:0] regWdata,
    input wire logic regWr,
    input wire logic regRd,
    output logic [7:0] regRdata,
    // bus controller side
    input wire logic busAckIn,
    input wire logic busReqOutIn,
    input wire logic [4:0] chipSelIn,
    output logic busReqInOut,
    output logic busReqInValid,
    // pins
    input wire logic [PINS-1:0] pinIn,
    output logic [PINS-1:0] pinOut,
    output logic [PINS-1:0] pinOe
);
    import pgp_pkg::*;

    typedef struct packed {
        logic strapped;
        logic [PINS-1:0] dir;
        logic [PINS-1:0] odata;
        logic [11:0] ctrl;
        logic [7:0] rdata;
        logic [PINS-1:0] pinOut;
        logic [PINS-1:0] pinOe;
        logic busReq;
        logic busReqValid;
    } pgp_state_s;

    pgp_state_s st_r;
    pgp_state_s st_nxt;
    pgp_mux_if mx();
    logic [PINS-1:0] pinView;

    assign mx.dir = st_r.dir;
    assign mx.odata = st_r.odata;
    assign mx.mode = st_r.ctrl[`PGP_CTRL_MODE_MSB:`PGP_CTRL_MODE_LSB];
    assign mx.external_expansion_enable = st_r.ctrl[`PGP_CTRL_EXTERNAL_EXPANSION_ENABLE];
    assign mx.brle = st_r.ctrl[`PGP_CTRL_BRLE];
    assign mx.brqoe = st_r.ctrl[`PGP_CTRL_BRQOE];
    assign mx.chip_select_seven_enable = st_r.ctrl[`PGP_CTRL_CHIP_SELECT_SEVEN_ENABLE];
    assign mx.cse = st_r.ctrl[`PGP_CTRL_CSE_MSB:`PGP_CTRL_CSE_LSB];
    assign mx.backOut = busAckIn;
    assign mx.brqOut = busReqOutIn;
    assign mx.csOut = chipSelIn;

    pgp_pin_mux u_mux
    (
        .m(mx)
    );

    // per-bit pin-state view
    genvar g;
    generate
        for (g = 0; g < PINS; g++)
        begin : g_view
            assign pinView[g] = st_r.dir[g] ? st_r.odata[g] : pinIn[g];
        end
    endgenerate

    always_comb
    begin
        st_nxt = st_r;
        // catch the operating mode strap once after reset release
        if (!st_r.strapped)
        begin
            st_nxt.strapped = 1'b1;
            st_nxt.ctrl[`PGP_CTRL_MODE_MSB:`PGP_CTRL_MODE_LSB] = opMode;
            st_nxt.dir[0] = (opMode == `PGP_MODE_1) || (opMode == `PGP_MODE_2);
        end
        if (regWr)
        begin
            case (regAddr)
                `PGP_ADDR_DIR: st_nxt.dir = regWdata[PINS-1:0];
                `PGP_ADDR_ODATA: st_nxt.odata = regWdata[PINS-1:0];
                `PGP_ADDR_CTRL:
                begin
                    st_nxt.ctrl[`PGP_CTRL_CSE_MSB:`PGP_CTRL_EXTERNAL_EXPANSION_ENABLE] =
                        {regWdata[7:4], 1'b0, regWdata[3:0]};
                end
                default: st_nxt.ctrl = st_nxt.ctrl; // pin-state writes ignored
            endcase
        end
        st_nxt.rdata = 8'h00;
        if (regRd)
        begin
            case (regAddr)
                `PGP_ADDR_DIR: st_nxt.rdata = 8'h00;
                `PGP_ADDR_ODATA: st_nxt.rdata = {1'b0, st_r.odata};
                `PGP_ADDR_PINS: st_nxt.rdata = {1'b0, pinView};
                `PGP_ADDR_CTRL: st_nxt.rdata = {st_r.ctrl[`PGP_CTRL_CSE_MSB:`PGP_CTRL_CSE_LSB],
                    st_r.ctrl[`PGP_CTRL_CHIP_SELECT_SEVEN_ENABLE:`PGP_CTRL_EXTERNAL_EXPANSION_ENABLE]};
                default: st_nxt.rdata = 8'h00;
            endcase
        end
        st_nxt.pinOut = mx.pinOut;
        st_nxt.pinOe = mx.pinOe;
        st_nxt.busReq = pinIn[6];
        st_nxt.busReqValid = !mx.pinOe[6] && !mx.gpioDrive[6] && mx.brle &&
            ((mx.mode != `PGP_MODE_7) || mx.external_expansion_enable);
    end

    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            st_r.strapped <= 1'b0;
            st_r.dir <= `PGP_DIR_RST;
            st_r.odata <= `PGP_ODATA_RST;
            st_r.ctrl <= `PGP_CTRL_RST;
            st_r.rdata <= 8'h00;
            st_r.pinOut <= '0;
            st_r.pinOe <= '0;
            st_r.busReq <= 1'b0;
            st_r.busReqValid <= 1'b0;
        end
        else
        begin
            st_r <= st_nxt;
        end
    end

    assign regRdata = st_r.rdata;
    assign pinOut = st_r.pinOut;
    assign pinOe = st_r.pinOe;
    assign busReqInOut = st_r.busReq;
    assign busReqInValid = st_r.busReqValid;

    // odata bit 7 never exists, read returns zero in that lane
    property p_odata_bit7;
        @(posedge clk) disable iff (!rstn)
        (regRd && regAddr == `PGP_ADDR_ODATA) |=> (regRdata[7] == 1'b0);
    endproperty
    a_odata_bit7: assert property (p_odata_bit7)
        else $error("odata bit 7 not zero");

    property p_odata_wr;
        @(posedge clk) disable iff (!rstn)
        (regWr && regAddr == `PGP_ADDR_ODATA) |=> (st_r.odata == $past(regWdata[PINS-1:0]));
    endproperty
    a_odata_wr: assert property (p_odata_wr)
        else $error("odata write lost");

    property p_dir_wr;
        @(posedge clk) disable iff (!rstn)
        (regWr && regAddr == `PGP_ADDR_DIR) |=> (st_r.dir == $past(regWdata[PINS-1:0]));
    endproperty
    a_dir_wr: assert property (p_dir_wr)
        else $error("dir write lost");

    property p_dir_read;
        @(posedge clk) disable iff (!rstn)
        (regRd && regAddr == `PGP_ADDR_DIR) |=> (regRdata == 8'h00);
    endproperty
    a_dir_read: assert property (p_dir_read)
        else $error("dir read not blanked");

    property p_out_read;
        @(posedge clk) disable iff (!rstn)
        (regRd && regAddr == `PGP_ADDR_PINS && st_r.dir[1]) |=>
            (regRdata[1] == $past(st_r.odata[1]));
    endproperty
    a_out_read: assert property (p_out_read)
        else $error("output pin read wrong");

    property p_in_read;
        @(posedge clk) disable iff (!rstn)
        (regRd && regAddr == `PGP_ADDR_PINS && !st_r.dir[1]) |=> (regRdata[1] == $past(pinIn[1]));
    endproperty
    a_in_read: assert property (p_in_read)
        else $error("input pin read wrong");

    property p_pins_nowr;
        @(posedge clk) disable iff (!rstn)
        (regWr && regAddr == `PGP_ADDR_PINS) |=> $stable(st_r.odata) && $stable(st_r.dir);
    endproperty
    a_pins_nowr: assert property (p_pins_nowr)
        else $error("pin-state write had effect");

    property p_gpio_only;
        @(posedge clk) disable iff (!rstn)
        (st_r.strapped && mx.mode == `PGP_MODE_7 && !mx.external_expansion_enable) |=>
            (pinOe == $past(st_r.dir)) && ((pinOut & pinOe) == ($past(st_r.odata) & pinOe));
    endproperty
    a_gpio_only: assert property (p_gpio_only)
        else $error("bus function in single-chip mode");

    property p_brqo;
        @(posedge clk) disable iff (!rstn)
        (mx.brle && mx.brqoe && mx.mode != `PGP_MODE_7) |=>
            pinOe[4] && pinOut[4] == $past(busReqOutIn);
    endproperty
    a_brqo: assert property (p_brqo)
        else $error("bus request out not on pin 4");

    property p_back;
        @(posedge clk) disable iff (!rstn)
        (mx.brle && mx.mode != `PGP_MODE_7) |=> pinOe[5] && !pinOe[6];
    endproperty
    a_back: assert property (p_back)
        else $error("bus ack/request pins wrong");

    property p_cs;
        @(posedge clk) disable iff (!rstn)
        (mx.cse[0] && mx.mode != `PGP_MODE_7) |=>
            pinOe[0] == $past(st_r.dir[0]) && pinOut[0] == $past(chipSelIn[0]);
    endproperty
    a_cs: assert property (p_cs)
        else $error("chip select 0 not on pin 0");

    property p_cs7;
        @(posedge clk) disable iff (!rstn)
        (mx.chip_select_seven_enable && !mx.brqoe && mx.mode != `PGP_MODE_7) |=>
            pinOe[4] == $past(st_r.dir[4]) && pinOut[4] == $past(chipSelIn[4]);
    endproperty
    a_cs7: assert property (p_cs7)
        else $error("chip select 7 not on pin 4");

    property p_gpio4;
        @(posedge clk) disable iff (!rstn)
        (!mx.chip_select_seven_enable && !mx.brle) |=>
            pinOe[4] == $past(st_r.dir[4]) && pinOut[4] == $past(st_r.odata[4]);
    endproperty
    a_gpio4: assert property (p_gpio4)
        else $error("pin 4 gpio wrong");

    // the strap lands on the first clean edge and is sampled one edge later, so wait for it
    property p_strap;
        @(posedge clk) disable iff (!rstn)
        (!st_r.strapped ##1 st_r.strapped) |->
            st_r.dir[0] == ($past(opMode) == `PGP_MODE_1 || $past(opMode) == `PGP_MODE_2);
    endproperty
    a_strap: assert property (p_strap)
        else $error("dir bit 0 reset wrong");

    property p_dir_rst;
        @(posedge clk) disable iff (!rstn)
        !st_r.strapped |-> st_r.dir[PINS-1:1] == '0;
    endproperty
    a_dir_rst: assert property (p_dir_rst)
        else $error("dir upper bits not cleared at reset");

    property p_odata_rst;
        @(posedge clk) disable iff (!rstn)
        !st_r.strapped |-> st_r.odata == '0;
    endproperty
    a_odata_rst: assert property (p_odata_rst)
        else $error("odata not cleared at reset");

    property p_odata_hold;
        @(posedge clk) disable iff (!rstn)
        !(regWr && regAddr == `PGP_ADDR_ODATA) |=> $stable(st_r.odata);
    endproperty
    a_odata_hold: assert property (p_odata_hold)
        else $error("odata changed without a write");

    property p_dir_hold;
        @(posedge clk) disable iff (!rstn)
        (st_r.strapped && !(regWr && regAddr == `PGP_ADDR_DIR)) |=> $stable(st_r.dir);
    endproperty
    a_dir_hold: assert property (p_dir_hold)
        else $error("dir changed without a write");

    property p_bus_request_in_valid;
        @(posedge clk) disable iff (!rstn)
        st_r.strapped |=>
            busReqInValid == $past(mx.brle && ((mx.mode != `PGP_MODE_7) || mx.external_expansion_enable));
    endproperty
    a_bus_request_in_valid: assert property (p_bus_request_in_valid)
        else $error("bus request input flag wrong");

    property p_bus_request_in_level;
        @(posedge clk) disable iff (!rstn)
        st_r.strapped |=> busReqInOut == $past(pinIn[6]);
    endproperty
    a_bus_request_in_level: assert property (p_bus_request_in_level)
        else $error("bus request input level wrong");

    property p_back_level;
        @(posedge clk) disable iff (!rstn)
        (mx.brle && (mx.mode != `PGP_MODE_7 || mx.external_expansion_enable)) |=> pinOut[5] == $past(busAckIn);
    endproperty
    a_back_level: assert property (p_back_level)
        else $error("bus acknowledge level wrong");

    property p_gpio_all;
        @(posedge clk) disable iff (!rstn)
        (!mx.brle && !mx.chip_select_seven_enable && mx.cse == 4'h0) |=>
            pinOe == $past(st_r.dir) && (pinOut & pinOe) == ($past(st_r.odata) & pinOe);
    endproperty
    a_gpio_all: assert property (p_gpio_all)
        else $error("gpio drive wrong");

    property p_cs_in;
        @(posedge clk) disable iff (!rstn)
        (mx.cse[0] && !st_r.dir[0]) |=> !pinOe[0];
    endproperty
    a_cs_in: assert property (p_cs_in)
        else $error("chip select pin driven as input");

    property p_cs7_in;
        @(posedge clk) disable iff (!rstn)
        (mx.chip_select_seven_enable && !(mx.brle && mx.brqoe) && !st_r.dir[4]) |=> !pinOe[4];
    endproperty
    a_cs7_in: assert property (p_cs7_in)
        else $error("chip select 7 pin driven as input");

    property p_cs3;
        @(posedge clk) disable iff (!rstn)
        (mx.cse[3] && (mx.mode != `PGP_MODE_7 || mx.external_expansion_enable)) |=>
            pinOe[3] == $past(st_r.dir[3]) && pinOut[3] == $past(chipSelIn[3]);
    endproperty
    a_cs3: assert property (p_cs3)
        else $error("chip select 3 not on pin 3");

    property p_brqo_exp;
        @(posedge clk) disable iff (!rstn)
        (mx.mode == `PGP_MODE_7 && mx.external_expansion_enable && mx.brle && mx.brqoe) |=>
            pinOe[4] && pinOut[4] == $past(busReqOutIn);
    endproperty
    a_brqo_exp: assert property (p_brqo_exp)
        else $error("bus request out missing with expansion");

    property p_pins_bit7;
        @(posedge clk) disable iff (!rstn)
        (regRd && regAddr == `PGP_ADDR_PINS) |=> (regRdata[7] == 1'b0);
    endproperty
    a_pins_bit7: assert property (p_pins_bit7)
        else $error("pin-state bit 7 not zero");
endmodule
`default_nettype wire

/* rtl/pgp_map.svh */
`ifndef PGP_MAP_SVH
`define PGP_MAP_SVH
// register offsets on the plain register port
`define PGP_ADDR_DIR 4'h0
`define PGP_ADDR_ODATA 4'h1
`define PGP_ADDR_PINS 4'h2
`define PGP_ADDR_CTRL 4'h3
// control register field positions
`define PGP_CTRL_MODE_LSB 0
`define PGP_CTRL_MODE_MSB 2
`define PGP_CTRL_EXTERNAL_EXPANSION_ENABLE 3
`define PGP_CTRL_BRLE 4
`define PGP_CTRL_BRQOE 5
`define PGP_CTRL_CHIP_SELECT_SEVEN_ENABLE 6
`define PGP_CTRL_CSE_LSB 8
`define PGP_CTRL_CSE_MSB 11
// reset values
`define PGP_DIR_RST 7'h00
`define PGP_ODATA_RST 7'h00
`define PGP_CTRL_RST 12'h000
// operating mode codes
`define PGP_MODE_1 3'h1
`define PGP_MODE_2 3'h2
`define PGP_MODE_4 3'h4
`define PGP_MODE_7 3'h7
`endif

/* rtl/pgp_pkg.sv */
package pgp_pkg;
    typedef logic [2:0] pgp_mode_t;
    typedef logic [6:0] pgp_pins_t;
    typedef enum logic [2:0] {
        PGP_GPIO = 3'h1,
        PGP_BUSCTL = 3'h2,
        PGP_CHIPSEL = 3'h4
    } pgp_fn_e;
endpackage

/* rtl/pgp_mux_if.sv */
`timescale 1ns/100ps
`default_nettype none
interface pgp_mux_if;
    import pgp_pkg::*;
    pgp_pins_t dir;
    pgp_pins_t odata;
    logic [2:0] mode;
    logic external_expansion_enable;
    logic brle;
    logic brqoe;
    logic chip_select_seven_enable;
    logic [3:0] cse;
    logic backOut;
    logic brqOut;
    logic [4:0] csOut;
    pgp_pins_t pinOut;
    pgp_pins_t pinOe;
    pgp_pins_t gpioDrive;
    modport cfg (output dir, odata, mode, external_expansion_enable, brle, brqoe, chip_select_seven_enable, cse, backOut, brqOut,
        csOut, input pinOut, pinOe, gpioDrive);
    modport mux (input dir, odata, mode, external_expansion_enable, brle, brqoe, chip_select_seven_enable, cse, backOut, brqOut,
        csOut, output pinOut, pinOe, gpioDrive);
endinterface
`default_nettype wire

/* rtl/pgp_pin_mux.sv */
`include "pgp_map.svh"
`timescale 1ns/100ps
`default_nettype none
module pgp_pin_mux
(
    pgp_mux_if.mux m
);
    import pgp_pkg::*;
    logic busMode;
    logic brlOn;
    always_comb
    begin
        // bus functions exist in modes 1,2,4 and in mode 7 with expansion on
        busMode = (m.mode != `PGP_MODE_7) || m.external_expansion_enable;
        brlOn = busMode && m.brle;
    end
    always_comb
    begin
        m.pinOut = m.odata;
        m.pinOe = m.dir;
        m.gpioDrive = m.dir;
        if (brlOn)
        begin
            m.pinOe[6] = 1'b0;
            m.gpioDrive[6] = 1'b0;
            m.pinOut[5] = m.backOut;
            m.pinOe[5] = 1'b1;
            m.gpioDrive[5] = 1'b0;
        end
        if (brlOn && m.brqoe)
        begin
            m.pinOut[4] = m.brqOut;
            m.pinOe[4] = 1'b1;
            m.gpioDrive[4] = 1'b0;
        end
        else if (busMode && m.chip_select_seven_enable)
        begin
            m.pinOut[4] = m.csOut[4];
            m.gpioDrive[4] = 1'b0;
        end
        for (int i = 0; i < 4; i++)
        begin
            if (busMode && m.cse[i])
            begin
                m.pinOut[i] = m.csOut[i];
                m.gpioDrive[i] = 1'b0;
            end
        end
    end
endmodule
`default_nettype wire

/* dv/pgp_pin_model.sv */
`timescale 1ns/100ps
`default_nettype none
module pgp_pin_model
(
    // clock
    input wire logic clk,
    // port side
    input wire pgp_pkg::pgp_pins_t pinOut,
    input wire pgp_pkg::pgp_pins_t pinOe,
    // far side drive
    input wire pgp_pkg::pgp_pins_t extVal,
    input wire pgp_pkg::pgp_pins_t extEn,
    // resolved level
    output var pgp_pkg::pgp_pins_t pinIn
);
    import pgp_pkg::*;
    pgp_pins_t float_r = 7'h55;
    // a pin nobody drives shows a changing pattern, never a held value
    always_ff @(posedge clk)
        float_r <= ~float_r;
    // the far side only drives pins the port leaves undriven
    always_comb
        pinIn = (pinOe & pinOut) |
            (~pinOe & ((extEn & extVal) | (~extEn & float_r)));
endmodule
`default_nettype wire

/* dv/testbench.sv */
`include "pgp_map.svh"
`timescale 1ns/100ps
`default_nettype none
module testbench;
    import pgp_pkg::*;
    logic clk = 1'b0;
    logic rstn = 1'b0;
    pgp_mode_t opMode = 3'h1;
    logic [3:0] regAddr = 4'h0;
    logic [7:0] regWdata = 8'h00;
    logic regWr = 1'b0;
    logic regRd = 1'b0;
    logic [7:0] regRdata;
    logic busAckIn = 1'b0;
    logic busReqOutIn = 1'b0;
    logic [4:0] chipSelIn = 5'h00;
    logic busReqInOut;
    logic busReqInValid;
    pgp_pins_t pinIn;
    pgp_pins_t pinOut;
    pgp_pins_t pinOe;
    pgp_pins_t extVal = 7'h00;
    pgp_pins_t extEn = 7'h00;
    pgp_mode_t modes [4] = '{3'h1, 3'h2, 3'h4, 3'h7};
    int fail_count = 0;
    int tests_run = 0;
    int cycles = 0;
    logic [31:0] seed = 32'h00008955;

    pgp_port_g #(.PINS(7)) i_dut (.clk(clk), .rstn(rstn), .opMode(opMode), .regAddr(regAddr),
        .regWdata(regWdata), .regWr(regWr), .regRd(regRd), .regRdata(regRdata),
        .busAckIn(busAckIn), .busReqOutIn(busReqOutIn), .chipSelIn(chipSelIn),
        .busReqInOut(busReqInOut), .busReqInValid(busReqInValid), .pinIn(pinIn),
        .pinOut(pinOut), .pinOe(pinOe));
    pgp_pin_model i_pins (.clk(clk), .pinOut(pinOut), .pinOe(pinOe), .extVal(extVal),
        .extEn(extEn), .pinIn(pinIn));

    initial
        forever #2.5 clk = ~clk;

    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] v;
        v = s ^ (s << 13);
        v = v ^ (v >> 17);
        return v ^ (v << 5);
    endfunction

    // expected {enable, drive} of the seven pins
    function automatic logic [13:0] expPins(input pgp_pins_t d, input pgp_pins_t o,
        input logic [7:0] c, input logic bus);
        pgp_pins_t oe;
        pgp_pins_t ov;
        oe = d;
        ov = o;
        if (bus && c[1])
        begin
            oe[6] = 1'b0;
            oe[5] = 1'b1;
            ov[5] = busAckIn;
        end
        if (bus && c[1] && c[2])
        begin
            oe[4] = 1'b1;
            ov[4] = busReqOutIn;
        end
        else if (bus && c[3])
            ov[4] = chipSelIn[4];
        for (int n = 0; n < 4; n++)
            if (bus && c[4 + n])
                ov[n] = chipSelIn[n];
        return {oe, ov & oe};
    endfunction

    task automatic check(input logic [15:0] seen, input logic [15:0] want);
        tests_run++;
        if (seen !== want)
        begin
            fail_count++;
            $display("ERROR at %0t: seen %h expected %h", $time, seen, want);
        end
    endtask

    task automatic wr(input logic [3:0] a, input logic [7:0] v);
        @(posedge clk);
        regRd <= 1'b0;
        regWr <= 1'b1;
        regAddr <= a;
        regWdata <= v;
    endtask

    task automatic rd(input logic [3:0] a, output logic [7:0] v);
        @(posedge clk);
        regWr <= 1'b0;
        regRd <= 1'b1;
        regAddr <= a;
        @(posedge clk);
        regRd <= 1'b0;
        #1;
        v = regRdata;
    endtask

    task automatic conclude;
        $display("Comparisons %0d, mismatches %0d", tests_run, fail_count);
        if (fail_count == 0 && tests_run > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    always @(posedge clk)
    begin
        cycles <= cycles + 1;
        if (cycles == 8000)
        begin
            fail_count++;
            conclude();
        end
    end

    initial
    begin
        logic [31:0] r;
        logic [7:0] ctl;
        logic [7:0] rv;
        logic [13:0] e;
        pgp_pins_t d;
        pgp_pins_t o;
        logic bus;
        pgp_pins_t pv;
        for (int m = 0; m < 4; m++)
        begin
            opMode <= modes[m];
            rstn <= 1'b0;
            repeat (20) @(posedge clk);
            rstn <= 1'b1;
            repeat (3) @(posedge clk);
            #1;
            check(pinOe, {6'h00, m < 2});
            rd(`PGP_ADDR_ODATA, rv);
            check(rv, 8'h00);
            extEn <= 7'h7F;
            for (int k = 0; k < 30; k++)
            begin
                seed = xs(seed);
                r = seed;
                d = r[6:0];
                o = r[13:7];
                ctl = (k < 2) ? {7'h7F, k[0]} : r[21:14];
                bus = (modes[m] != 3'h7) || ctl[0];
                @(posedge clk);
                busAckIn <= r[22];
                busReqOutIn <= r[23];
                chipSelIn <= r[28:24];
                seed = xs(seed);
                extVal <= seed[6:0];
                wr(`PGP_ADDR_DIR, {seed[7], d});
                wr(`PGP_ADDR_ODATA, {seed[8], o});
                wr(`PGP_ADDR_CTRL, ctl);
                wr(`PGP_ADDR_PINS, ~{1'b0, o});
                rd(4'hF, rv);
                check(rv, 8'h00);
                rd(`PGP_ADDR_DIR, rv);
                check(rv, 8'h00);
                repeat (2) @(posedge clk);
                #1;
                e = expPins(d, o, ctl, bus);
                check({pinOe, pinOut & pinOe}, e);
                check({pinOe, pinOut & pinOe}, e);
                check({busReqInValid, busReqInOut & busReqInValid},
                    {bus & ctl[1], extVal[6] & bus & ctl[1]});
                rd(`PGP_ADDR_ODATA, rv);
                check(rv, {1'b0, o});
                rd(`PGP_ADDR_PINS, rv);
                pv = (d & o) | (~d & (e[6:0] | (~e[13:7] & extVal)));
                check(rv[6:0], pv);
            end
        end
        conclude();
    end
endmodule
`default_nettype wire
